// >>> hdl/tpm_pin_mux.sv
// Pin logic for the chip-select, converter and serial-bus ports with APB access
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps

module tpm_pin_mux
   import tpm_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   output logic      [DATA_W-1:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Chip-select port pins
   input  wire logic [CS_W-1:0]   cs_pin_in,
   output logic      [CS_W-1:0]   cs_pin_out,
   output logic      [CS_W-1:0]   cs_pin_oe_n,
   output logic      [CS_W-1:0]   cs_pin_pullup,
   // Chip selects from the memory controller, active low
   input  wire logic              chip_select_zero_n,
   input  wire logic              chip_select_one_n,
   input  wire logic              chip_select_two_n,
   // Converter port pins
   input  wire logic [AN_W-1:0]   analog_pin_in,
   output logic                   converter_trigger_pin,
   // Serial-bus port pins
   input  wire logic [SB_W-1:0]   sb_pin_in,
   output logic      [SB_W-1:0]   sb_pin_out,
   output logic      [SB_W-1:0]   sb_pin_oe_n,
   // Serial bus interface side
   input  wire logic              sbi_i2c_mode,
   input  wire logic              sbi_sck_out,
   input  wire logic              sbi_sck_drive,
   input  wire logic              sbi_so_sda_out,
   input  wire logic              sbi_scl_out,
   output logic                   sbi_sck_in,
   output logic                   sbi_sda_in,
   output logic                   sbi_si_scl_in,
   output logic                   external_interrupt_zero
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [CS_W-1:0]   cs_sync1;
      logic [CS_W-1:0]   cs_sync2;
      logic [AN_W-1:0]   an_sync1;
      logic [AN_W-1:0]   an_sync2;
      logic [SB_W-1:0]   sb_sync1;
      logic [SB_W-1:0]   sb_sync2;
      logic [CS_W-1:0]   cs_latch;
      logic [CS_W-1:0]   cs_dir;
      logic [CS_W-1:0]   cs_func;
      logic [SB_W-1:0]   sb_latch;
      logic [SB_W-1:0]   sb_dir;
      logic [SB_W-1:0]   sb_func;
      logic [CS_W-1:0]   cs_out;
      logic [CS_W-1:0]   cs_oe_n;
      logic [CS_W-1:0]   cs_pullup;
      logic [SB_W-1:0]   sb_out;
      logic [SB_W-1:0]   sb_oe_n;
      logic [DATA_W-1:0] rdata;
   } tpm_state_s;

   tpm_state_s st;
   tpm_state_s next_st;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   function automatic tpm_sel_e decode_addr(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-3:0] idx;
      tpm_sel_e          sel;
      idx = addr[ADDR_W-1:2];
      sel = TPM_SEL_NONE;
      if (addr[1:0] == 2'h0) begin
         case (idx)
            10'(IDX_CS_DATA): sel = TPM_SEL_CS_DATA;
            10'(IDX_ANALOG):  sel = TPM_SEL_ANALOG;
            10'(IDX_CS_DIR):  sel = TPM_SEL_CS_DIR;
            10'(IDX_CS_FUNC): sel = TPM_SEL_CS_FUNC;
            10'(IDX_SB_DATA): sel = TPM_SEL_SB_DATA;
            10'(IDX_SB_DIR):  sel = TPM_SEL_SB_DIR;
            10'(IDX_SB_FUNC): sel = TPM_SEL_SB_FUNC;
            default:          sel = TPM_SEL_NONE;
         endcase
      end
      return sel;
   endfunction

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   // Data words read the synced pins, never the latch
   // Write-only and unmapped words read as zero
   function automatic logic [DATA_W-1:0] read_word(
      input tpm_sel_e        rsel,
      input logic [CS_W-1:0] cs_lvl,
      input logic [AN_W-1:0] an_lvl,
      input logic [SB_W-1:0] sb_lvl
   );
      logic [DATA_W-1:0] word;
      word = '0;
      case (rsel)
         TPM_SEL_CS_DATA: word = DATA_W'(cs_lvl);
         TPM_SEL_ANALOG:  word = DATA_W'(an_lvl);
         TPM_SEL_SB_DATA: word = DATA_W'(sb_lvl);
         default:         word = '0;
      endcase
      return word;
   endfunction

   // ---------------------------------------------------------------
   // Alternate function ownership
   // ---------------------------------------------------------------
   // Both bits needed: with function set first, port data never leaks out
   function automatic logic alt_owned(input logic func_bit, input logic dir_bit);
      return func_bit && dir_bit;
   endfunction

   tpm_sel_e    sel;
   logic        wr_en;
   logic        setup;
   logic [CS_W-1:0] cs_alt;

   assign sel    = decode_addr(paddr);
   assign setup  = psel && !penable;
   assign wr_en  = psel && penable && pwrite;
   assign cs_alt = {chip_select_two_n, chip_select_one_n, chip_select_zero_n};

   // Zero wait states; unmapped words answer with an error
   // Writes to the converter word are dropped without an error
   assign pready  = 1'b1;
   assign pslverr = psel && penable && (sel == TPM_SEL_NONE);

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;

      // Pins cross in from the board through two flops
      next_st.cs_sync1 = cs_pin_in;
      next_st.cs_sync2 = st.cs_sync1;
      next_st.an_sync1 = analog_pin_in;
      next_st.an_sync2 = st.an_sync1;
      next_st.sb_sync1 = sb_pin_in;
      next_st.sb_sync2 = st.sb_sync1;

      // Register writes
      // Converter word has no storage; writes to it fall through
      if (wr_en) begin
         case (sel)
            TPM_SEL_CS_DATA: next_st.cs_latch = pwdata[CS_W-1:0];
            TPM_SEL_CS_DIR:  next_st.cs_dir   = pwdata[CS_W-1:0];
            TPM_SEL_CS_FUNC: next_st.cs_func  = pwdata[CS_W-1:0];
            TPM_SEL_SB_DATA: next_st.sb_latch = pwdata[SB_W-1:0];
            TPM_SEL_SB_DIR:  next_st.sb_dir   = pwdata[SB_W-1:0];
            TPM_SEL_SB_FUNC: next_st.sb_func  = pwdata[SB_W-1:0];
            default: ;
         endcase
      end

      // Read data is captured in the setup cycle so it stands in the access cycle
      if (setup) begin
         next_st.rdata = read_word(sel, st.cs_sync2, st.an_sync2, st.sb_sync2);
      end

      // Chip-select port drive
      for (int i = 0; i < CS_W; i++) begin
         // Chip-select value prepared even while the pin is still an input
         next_st.cs_out[i]    = st.cs_func[i] ? cs_alt[i] : st.cs_latch[i];
         next_st.cs_oe_n[i]   = !st.cs_dir[i];
         // Pull-up follows the latch only while the pin is an input
         next_st.cs_pullup[i] = !st.cs_dir[i] && st.cs_latch[i];
      end

      // Serial-bus port drive, plain port by default
      // Alternate drive needs the direction bit as well
      for (int i = 0; i < SB_W; i++) begin
         next_st.sb_out[i]  = st.sb_latch[i];
         next_st.sb_oe_n[i] = !st.sb_dir[i];
      end

      // Pin 0: serial clock, two-way in synchronous mode
      if (alt_owned(st.sb_func[SB_SCK_BIT], st.sb_dir[SB_SCK_BIT])) begin
         next_st.sb_out[SB_SCK_BIT]  = sbi_sck_out;
         next_st.sb_oe_n[SB_SCK_BIT] = sbi_i2c_mode || !sbi_sck_drive;
      end

      // Pin 1: open-drain data in bus mode, push-pull data out otherwise
      if (alt_owned(st.sb_func[SB_SDA_BIT], st.sb_dir[SB_SDA_BIT])) begin
         if (sbi_i2c_mode) begin
            next_st.sb_out[SB_SDA_BIT]  = 1'b0;
            next_st.sb_oe_n[SB_SDA_BIT] = sbi_so_sda_out;
         end else begin
            next_st.sb_out[SB_SDA_BIT]  = sbi_so_sda_out;
            next_st.sb_oe_n[SB_SDA_BIT] = 1'b0;
         end
      end

      // Pin 2: receive input in synchronous mode, open-drain clock in bus mode
      if (alt_owned(st.sb_func[SB_SCL_BIT], st.sb_dir[SB_SCL_BIT])) begin
         next_st.sb_out[SB_SCL_BIT]  = 1'b0;
         next_st.sb_oe_n[SB_SCL_BIT] = sbi_i2c_mode ? sbi_scl_out : 1'b1;
      end

      // Pin 3 has no drivable alternate; as an output it stays a plain port
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // Pins come up released with pull-ups on; synced copies read low at first
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st.cs_sync1  <= '0;
         st.cs_sync2  <= '0;
         st.an_sync1  <= '0;
         st.an_sync2  <= '0;
         st.sb_sync1  <= '0;
         st.sb_sync2  <= '0;
         st.cs_latch  <= RST_CS_LATCH;
         st.cs_dir    <= RST_CS_DIR;
         st.cs_func   <= RST_CS_FUNC;
         st.sb_latch  <= RST_SB_LATCH;
         st.sb_dir    <= RST_SB_DIR;
         st.sb_func   <= RST_SB_FUNC;
         st.cs_out    <= RST_CS_LATCH;
         st.cs_oe_n   <= '1;
         st.cs_pullup <= RST_CS_LATCH;
         st.sb_out    <= RST_SB_LATCH;
         st.sb_oe_n   <= '1;
         st.rdata     <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prdata                  = st.rdata;
   assign cs_pin_out              = st.cs_out;
   assign cs_pin_oe_n             = st.cs_oe_n;
   assign cs_pin_pullup           = st.cs_pullup;
   assign sb_pin_out              = st.sb_out;
   assign sb_pin_oe_n             = st.sb_oe_n;
   // Converter decides itself whether to honour the trigger
   assign converter_trigger_pin   = st.an_sync2[AN_TRIG_BIT];
   // Synced pin levels reach the peripherals two edges late
   assign sbi_sck_in              = st.sb_sync2[SB_SCK_BIT];
   assign sbi_sda_in              = st.sb_sync2[SB_SDA_BIT];
   assign sbi_si_scl_in           = st.sb_sync2[SB_SCL_BIT];
   // Interrupt input is fed whatever the pin's function setting
   assign external_interrupt_zero = st.sb_sync2[SB_INT_BIT];

endmodule

// >>> pkg/tpm_pkg.sv
// Constants and types for the three-port pin function multiplexer
package tpm_pkg;

   // ---------------------------------------------------------------
   // Bus and port widths
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W     = 12;
   localparam int unsigned DATA_W     = 32;
   localparam int unsigned CS_W       = 3;
   localparam int unsigned AN_W       = 4;
   localparam int unsigned SB_W       = 4;
   localparam int unsigned REG_W      = 8;

   // ---------------------------------------------------------------
   // Register indices; byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_CS_DATA   = 8'h0c;
   localparam logic [7:0] IDX_ANALOG    = 8'h0d;
   localparam logic [7:0] IDX_CS_DIR    = 8'h0e;
   localparam logic [7:0] IDX_CS_FUNC   = 8'h0f;
   localparam logic [7:0] IDX_SB_DATA   = 8'h10;
   localparam logic [7:0] IDX_SB_DIR    = 8'h11;
   localparam logic [7:0] IDX_SB_FUNC   = 8'h12;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [CS_W-1:0] RST_CS_LATCH = 3'h7;
   localparam logic [CS_W-1:0] RST_CS_DIR   = 3'h0;
   localparam logic [CS_W-1:0] RST_CS_FUNC  = 3'h0;
   localparam logic [SB_W-1:0] RST_SB_LATCH = 4'hf;
   localparam logic [SB_W-1:0] RST_SB_DIR   = 4'h0;
   localparam logic [SB_W-1:0] RST_SB_FUNC  = 4'h0;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int unsigned AN_TRIG_BIT  = 3;
   localparam int unsigned SB_SCK_BIT   = 0;
   localparam int unsigned SB_SDA_BIT   = 1;
   localparam int unsigned SB_SCL_BIT   = 2;
   localparam int unsigned SB_INT_BIT   = 3;

   // ---------------------------------------------------------------
   // Register selector
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      TPM_SEL_NONE    = 3'h0,
      TPM_SEL_CS_DATA = 3'h1,
      TPM_SEL_ANALOG  = 3'h2,
      TPM_SEL_CS_DIR  = 3'h3,
      TPM_SEL_CS_FUNC = 3'h4,
      TPM_SEL_SB_DATA = 3'h5,
      TPM_SEL_SB_DIR  = 3'h6,
      TPM_SEL_SB_FUNC = 3'h7
   } tpm_sel_e;

endpackage

// >>> test/tpm_board.sv
// Board-side model of the port pins: outside drivers and pull-ups
`timescale 1ns/100ps
module tpm_board #(parameter int W = 3) (
   input  wire logic [W-1:0] out,
   input  wire logic [W-1:0] oe_n,
   input  wire logic [W-1:0] pu,
   input  wire logic [W-1:0] ext,
   input  wire logic [W-1:0] ext_en,
   output logic      [W-1:0] pin
);
   // A released pin with no outside driver and no pull-up floats; show the inverse of the drive
   always_comb begin
      for (int i = 0; i < W; i++) begin
         pin[i] = !oe_n[i] ? out[i] : ext_en[i] ? ext[i] : pu[i] ? 1'h1 : ~out[i];
      end
   end
endmodule

// >>> test/tpm_pin_mux_chk.sv
// Port assertions for the pin multiplexer
`timescale 1ns/100ps
module tpm_pin_mux_chk
   import tpm_pkg::*;
(
   input wire logic              clk,
   input wire logic              sys_rst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic              pslverr,
   input wire logic [CS_W-1:0]   cs_pin_oe_n,
   input wire logic [CS_W-1:0]   cs_pin_pullup,
   input wire logic [AN_W-1:0]   analog_pin_in,
   input wire logic              converter_trigger_pin,
   input wire logic [SB_W-1:0]   sb_pin_in,
   input wire logic [SB_W-1:0]   sb_pin_oe_n,
   input wire logic              external_interrupt_zero
);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic acc, wr_dir;
   assign acc = psel && penable;
   assign wr_dir = acc && pwrite && paddr == 12'h038;
   chk_reset_inputs: assert property (disable iff (1'h0)
      sys_rst |-> &{cs_pin_oe_n, cs_pin_pullup, sb_pin_oe_n}) else $error("reset state wrong");
   chk_dir_to_oe: assert property (wr_dir
      |=> ##1 cs_pin_oe_n == ~$past(pwdata[2:0], 2)) else $error("direction not on pins");
   chk_oe_cause: assert property ($changed(cs_pin_oe_n)
      |-> $past(wr_dir, 2)) else $error("enable moved without a write");
   chk_pullup_only_in: assert property ((cs_pin_pullup & ~cs_pin_oe_n) == 3'h0)
      else $error("pull-up on an output");
   chk_trigger_level: assert property ($stable(analog_pin_in[3]) [*5]
      |-> converter_trigger_pin == analog_pin_in[3]) else $error("trigger lags pin");
   chk_int_level: assert property ($stable(sb_pin_in[3]) [*5]
      |-> external_interrupt_zero == sb_pin_in[3]) else $error("interrupt lags pin");
   chk_wo_read_zero: assert property (acc && !pwrite && paddr inside {12'h038, 12'h03c}
      |-> prdata == 32'h0) else $error("write-only read not zero");
   chk_map_err: assert property (acc |-> pslverr == !(paddr inside {12'h030, 12'h034,
      12'h038, 12'h03c, 12'h040, 12'h044, 12'h048})) else $error("error flag wrong");
   cover property (wr_dir);
   cover property (acc && !pwrite && paddr == 12'h034);
   cover property (acc && pslverr);
endmodule
bind tpm_pin_mux tpm_pin_mux_chk tpm_pin_mux_chk_i (.*);

// >>> test/tpm_pin_mux_tb.sv
// Self-checking bench for the pin multiplexer
`timescale 1ns/100ps
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin n_mismatch++; \
   $display("BAD %0t got %h exp %h", $time, g, x); end end
module tpm_pin_mux_tb import tpm_pkg::*; ;
   logic clk = 1'h0, sys_rst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, e;
   logic [ADDR_W-1:0] paddr = 12'h0;
   logic [DATA_W-1:0] pwdata = 32'h0, prdata, rv, r, lfsr = 32'hd651;
   logic pready, pslverr, converter_trigger_pin, sbi_sck_in, sbi_sda_in, sbi_si_scl_in;
   logic external_interrupt_zero, chip_select_zero_n = 1'h1, chip_select_one_n = 1'h1;
   logic chip_select_two_n = 1'h1, sbi_i2c_mode = 1'h0, sbi_sck_out = 1'h0;
   logic sbi_sck_drive = 1'h0, sbi_so_sda_out = 1'h0, sbi_scl_out = 1'h0;
   logic [CS_W-1:0] cs_pin_in, cs_pin_out, cs_pin_oe_n, cs_pin_pullup;
   logic [AN_W-1:0] analog_pin_in = 4'h0;
   logic [SB_W-1:0] sb_pin_in, sb_pin_out, sb_pin_oe_n, sb_ext = 4'h0, sb_en = 4'h0;
   int n_mismatch = 0, compares = 0, md, mf, ml, sd, sl, ex, rb;
   tpm_pin_mux tpm_pin_mux_i (.*);
   tpm_board #(.W(CS_W)) tpm_board_cs_i (.out(cs_pin_out), .oe_n(cs_pin_oe_n),
      .pu(cs_pin_pullup), .ext(3'h0), .ext_en(3'h0), .pin(cs_pin_in));
   tpm_board #(.W(SB_W)) tpm_board_sb_i (.out(sb_pin_out), .oe_n(sb_pin_oe_n),
      .pu(4'hf), .ext(sb_ext), .ext_en(sb_en), .pin(sb_pin_in));
   always #2.5 clk = ~clk;
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      rv = prdata;
      e = pslverr;
      {psel, penable} <= 2'h0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rst_chk();
      sys_rst <= 1'h1;
      idle(5);
      sys_rst <= 1'h0;
      `CHK({cs_pin_oe_n, cs_pin_out, cs_pin_pullup}, 9'h1ff)
      `CHK({sb_pin_oe_n, sb_pin_out}, 8'hff)
   endtask
   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      sys_rst = 1'h1;
      rst_chk();
      apb(1'h0, 12'h03c, 32'h0);
      `CHK(rv, 32'h0)
      $display("test reset done");
      for (int k = 0; k < 12; k++) begin
         r = rnd();
         mf = r[5:3];
         md = r[8:6];
         ml = r[11:9];
         apb(1'h1, 12'h030, ml);
         apb(1'h1, 12'h03c, mf);
         apb(1'h1, 12'h038, md);
         {chip_select_two_n, chip_select_one_n, chip_select_zero_n} <= r[14:12];
         idle(3);
         rb = 0;
         for (int i = 0; i < 3; i++) begin
            ex = mf[i] ? r[12+i] : ml[i];
            rb[i] = md[i] ? ex[0] : (ml[i] | !ex[0]);
            `CHK({cs_pin_oe_n[i], cs_pin_out[i]}, {!md[i], ex[0]})
            `CHK(cs_pin_pullup[i], !md[i] && ml[i])
         end
         apb(1'h0, 12'h030, 32'h0);
         `CHK(rv, rb)
      end
      $display("test chip-select port done");
      sb_en <= 4'hf;
      for (int k = 0; k < 8; k++) begin
         r = rnd();
         analog_pin_in <= r[3:0];
         sb_ext <= r[7:4];
         sd = r[11:8];
         sl = r[15:12];
         apb(1'h1, 12'h040, sl);
         apb(1'h1, 12'h048, 32'h0);
         apb(1'h1, 12'h044, sd);
         apb(1'h1, 12'h034, 32'hf);
         idle(4);
         ex = (sd & sl) | (~sd & r[7:4]);
         `CHK({sb_pin_oe_n, sb_pin_out}, {4'(~sd), 4'(sl)})
         `CHK({converter_trigger_pin, external_interrupt_zero}, {r[3], ex[3]})
         apb(1'h0, 12'h034, 32'h0);
         `CHK(rv, 32'(r[3:0]))
         apb(1'h0, 12'h040, 32'h0);
         `CHK(rv, 32'(ex[3:0]))
      end
      $display("test converter and serial port done");
      sb_en <= 4'h0;
      apb(1'h1, 12'h048, 32'hf);
      apb(1'h1, 12'h044, 32'hf);
      for (int k = 0; k < 8; k++) begin
         r = rnd();
         {sbi_i2c_mode, sbi_sck_out, sbi_sck_drive, sbi_so_sda_out, sbi_scl_out} <= r[4:0];
         idle(4);
         if (r[4]) begin
            `CHK({sb_pin_oe_n[2:0], sb_pin_out[2:1]}, {r[0], r[1], 3'h4})
            `CHK({sbi_si_scl_in, sbi_sda_in}, {r[0], r[1]})
         end else begin
            `CHK({sb_pin_oe_n[2:0], sb_pin_out[1:0], sbi_si_scl_in},
               {2'h2, !r[2], r[1], r[3], 1'h1})
         end
         `CHK(sbi_sck_in, (r[4] || !r[2]) ? 1'h1 : r[3])
      end
      $display("test alternate functions done");
      apb(1'h0, 12'h04c, 32'h0);
      `CHK({e, rv}, {1'h1, 32'h0})
      apb(1'h0, 12'h032, 32'h0);
      `CHK(e, 1'h1)
      rst_chk();
      $display("test refusal and second reset done");
      final_report();
   end
   // Whole run needs well under 4000 cycles
   initial begin
      #100000;
      n_mismatch++;
      final_report();
   end
endmodule
